// >>> ftp_pkg.sv
// package for the fast-interrupt top-priority pending summary block
// assumes a 32-bit register bus and 4-bit source priorities
`default_nettype none
package ftp_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 16;
	localparam int PRIO_W = 4;
	localparam logic [ADDR_W-1:0] TOP_PENDING_OFFSET = 16'hE260;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 16'hE2F0;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 16'hE2F4;
	localparam logic [DATA_W-1:0] TOP_PENDING_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] IRQ_MASK_RESET = 32'h00000000;
	// bits that carry a source; all others read zero
	localparam logic [DATA_W-1:0] SOURCE_BITS = 32'h7F0FF7D0;
	localparam int WAN_TX_FIQ_TOP = 30;
	localparam int WAN_RX_FIQ_TOP = 29;
	localparam int WAN_TX_NOBUF_FIQ_TOP = 28;
	localparam int WAN_RX_NOBUF_FIQ_TOP = 27;
	localparam int WAN_TX_STOPPED_FIQ_TOP = 26;
	localparam int WAN_RX_STOPPED_FIQ_TOP = 25;
	localparam int BUS_ERROR_FIQ_TOP = 24;
	localparam int WAN_WAKE_FIQ_TOP = 19;
	localparam int LAN_WAKE_FIQ_TOP = 18;
	localparam int LAN_TX_FIQ_TOP = 17;
	localparam int LAN_RX_FIQ_TOP = 16;
	localparam int LAN_TX_NOBUF_FIQ_TOP = 15;
	localparam int LAN_RX_NOBUF_FIQ_TOP = 14;
	localparam int LAN_TX_STOPPED_FIQ_TOP = 13;
	localparam int LAN_RX_STOPPED_FIQ_TOP = 12;
	localparam int USB_DEV_FIQ_TOP = 10;
	localparam int USB_HOST_OHCI_FIQ_TOP = 9;
	localparam int USB_HOST_EHCI_FIQ_TOP = 8;
	localparam int SD_HOST_FIQ_TOP = 7;
	localparam int CRYPTO_ENGINE_FIQ_TOP = 6;
	localparam int DRAM_CTRL_FIQ_TOP = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// one source as seen by the controller
	typedef struct packed {
		logic pending;
		logic enable;
		logic to_fiq;
		logic [PRIO_W-1:0] prio;
	} ftp_source_t;
	typedef enum logic [0:0] {
		WR_IDLE = 1'b0,
		WR_RESP = 1'b1
	} ftp_wr_state_t;
	typedef enum logic [0:0] {
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} ftp_rd_state_t;
endpackage
`default_nettype wire

// >>> ftp_resolve.sv
// top-priority resolver over all fast-interrupt sources
// assumes higher prio value wins; combinational
`timescale 1ns/100ps
`default_nettype none
module ftp_resolve
	import ftp_pkg::*;
#(
	parameter int N = DATA_W
)
(
	input wire ftp_source_t i_src [N],
	output logic [N-1:0] o_top
);
	logic [N-1:0] live;
	logic [PRIO_W-1:0] best;

	// a source counts only while pending, enabled and steered to fiq
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_live
			assign live[g] = i_src[g].pending & i_src[g].enable
				& i_src[g].to_fiq & SOURCE_BITS[g];
		end
	endgenerate

	always_comb
	begin
		best = '0;
		for (int k = 0; k < N; k++)
		begin
			if (live[k] && i_src[k].prio > best)
			begin
				best = i_src[k].prio;
			end
		end
	end

	// every live source at the best level is flagged, ties included
	generate
		for (g = 0; g < N; g++)
		begin : g_top
			assign o_top[g] = live[g] && (i_src[g].prio == best);
		end
	endgenerate
endmodule
`default_nettype wire

// >>> ftp_top.sv
// fast-interrupt top-priority pending summary with axi4-lite slave
// assumes source inputs synchronous to I_SYS_CLK
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
//Contract
//- Summary word at 0xE260 is read-only; writes leave it unchanged.
//- A bit is set only while its source was top pending fiq one clock earlier.
//- Sources tied at the top level are all flagged together.
//- Bits 30..25: wan tx, rx, tx nobuf, rx nobuf, tx stop, rx stop.
//- Bit 24 flags the bus error interrupt when top.
//- Bit 19 flags wan wake, bit 18 flags lan wake.
//- Bits 17..12: lan tx, rx, tx nobuf, rx nobuf, tx stop, rx stop.
//- Bit 10 usb device, bit 9 usb ohci, bit 8 usb ehci.
//- Bit 7 sd host, bit 6 crypto engine.
//- Bit 4 flags the dram controller interrupt when top.
module ftp_top
	import ftp_pkg::*;
(
	input wire logic I_SYS_CLK,
	input wire logic I_SRST,
	input wire ftp_source_t I_SRC [DATA_W],
	input wire logic [ADDR_W-1:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [DATA_W-1:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [ADDR_W-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [DATA_W-1:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic O_IRQ
);
	// ***************************************************
	// summary word
	// ***************************************************
	logic [DATA_W-1:0] top_now;
	logic [DATA_W-1:0] fiq_top_pending_word;
	logic [DATA_W-1:0] prev_word;
	logic [DATA_W-1:0] irq_status;
	logic [DATA_W-1:0] irq_mask;

	// bit map of sources fixed by port index
	// lan, usb, sd, crypto, dram share the same map
	ftp_resolve #(
		.N(DATA_W)
	) u_resolve (
		.i_src(I_SRC),
		.o_top(top_now)
	);

	// summary lags the sources by one clock
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_SRST)
		begin
			fiq_top_pending_word <= TOP_PENDING_RESET;
		end
		else
		begin
			fiq_top_pending_word <= top_now & SOURCE_BITS;
		end
	end

	// ***************************************************
	// interrupt: a bit rising into top-priority is an event
	// ***************************************************
	logic wr_fire;
	logic [ADDR_W-1:0] aw_addr;
	logic [DATA_W-1:0] w_data;
	logic [3:0] w_strb;
	logic [DATA_W-1:0] clr_mask;
	logic [DATA_W-1:0] be_mask;
	logic [DATA_W-1:0] rose;
	logic [DATA_W-1:0] irq_hit;
	logic hit_summary;
	logic hit_status;
	logic hit_mask;

	always_comb
	begin
		for (int b = 0; b < 4; b++)
		begin
			be_mask[b*8 +: 8] = {8{w_strb[b]}};
		end
	end

	// stored write address decoded once for mask, clear and response
	assign hit_summary = (aw_addr == TOP_PENDING_OFFSET);
	assign hit_status = (aw_addr == IRQ_STATUS_OFFSET);
	assign hit_mask = (aw_addr == IRQ_MASK_OFFSET);

	assign clr_mask = (wr_fire && hit_status)
		? (w_data & be_mask) : '0;

	// a source becoming top-priority is the interrupt event
	assign rose = fiq_top_pending_word & ~prev_word;
	assign irq_hit = irq_status & irq_mask;

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_SRST)
		begin
			prev_word <= TOP_PENDING_RESET;
		end
		else
		begin
			prev_word <= fiq_top_pending_word;
		end
	end

	// set wins over write-one-to-clear
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_SRST)
		begin
			irq_status <= '0;
		end
		else
		begin
			irq_status <= (irq_status & ~clr_mask) | rose;
		end
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_SRST)
		begin
			irq_mask <= IRQ_MASK_RESET;
		end
		else if (wr_fire && hit_mask)
		begin
			// byte lanes only; reserved bits never stick
			irq_mask <= ((irq_mask & ~be_mask) | (w_data & be_mask))
				& SOURCE_BITS;
		end
	end

	// ***************************************************
	// interrupt output
	// ***************************************************

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_SRST)
		begin
			O_IRQ <= 1'b0;
		end
		else
		begin
			O_IRQ <= |irq_hit;
		end
	end

	// ***************************************************
	// axi4-lite write channel
	// ***************************************************
	ftp_wr_state_t wr_state;
	logic aw_held;
	logic w_held;
	logic aw_take;
	logic w_take;
	logic wr_ok;

	assign O_AWREADY = (wr_state == WR_IDLE) && !aw_held;
	assign O_WREADY = (wr_state == WR_IDLE) && !w_held;
	assign aw_take = O_AWREADY && I_AWVALID;
	assign w_take = O_WREADY && I_WVALID;
	// act only on the stored copies, one clock after the later half
	assign wr_fire = (wr_state == WR_IDLE) && aw_held && w_held;
	// summary word takes no data but still answers okay
	assign wr_ok = hit_summary || hit_status || hit_mask;

	// each half waits here until both are in; either may come first
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_SRST)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_addr <= I_AWADDR;
			end
			if (w_take)
			begin
				w_data <= I_WDATA;
				w_strb <= I_WSTRB;
			end
			if (wr_fire)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
			else
			begin
				aw_held <= aw_held | aw_take;
				w_held <= w_held | w_take;
			end
		end
	end

	ftp_wr_state_t next_wr_state;
	always_comb
	begin
		case (wr_state)
			WR_IDLE: next_wr_state = wr_fire ? WR_RESP : WR_IDLE;
			WR_RESP: next_wr_state = I_BREADY ? WR_IDLE : WR_RESP;
			default: next_wr_state = WR_IDLE;
		endcase
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_SRST)
		begin
			wr_state <= WR_IDLE;
			O_BVALID <= 1'b0;
			O_BRESP <= RESP_OKAY;
		end
		else
		begin
			wr_state <= next_wr_state;
			O_BVALID <= (next_wr_state == WR_RESP);
			if (wr_fire)
			begin
				// summary word ignores writes
				O_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ***************************************************
	// axi4-lite read channel
	// ***************************************************
	ftp_rd_state_t rd_state;
	logic ar_take;

	assign O_ARREADY = (rd_state == RD_IDLE);
	assign ar_take = O_ARREADY && I_ARVALID;

	// one read in flight; address decoded when taken
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_SRST)
		begin
			rd_state <= RD_IDLE;
			O_RVALID <= 1'b0;
			O_RDATA <= '0;
			O_RRESP <= RESP_OKAY;
		end
		else
		begin
			case (rd_state)
				RD_IDLE:
				begin
					if (ar_take)
					begin
						rd_state <= RD_DATA;
						O_RVALID <= 1'b1;
						O_RRESP <= RESP_OKAY;
						case (I_ARADDR)
							TOP_PENDING_OFFSET: O_RDATA <= fiq_top_pending_word;
							IRQ_STATUS_OFFSET: O_RDATA <= irq_status;
							IRQ_MASK_OFFSET: O_RDATA <= irq_mask;
							default:
							begin
								O_RDATA <= '0;
								O_RRESP <= RESP_SLVERR;
							end
						endcase
					end
				end
				RD_DATA:
				begin
					if (I_RREADY)
					begin
						rd_state <= RD_IDLE;
						O_RVALID <= 1'b0;
					end
				end
				default:
				begin
					rd_state <= RD_IDLE;
					O_RVALID <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> ftp_top_properties.sv
// port checker for the fast-interrupt summary block
// assumes it is bound onto every ftp_top instance
`timescale 1ns/100ps
`default_nettype none
module ftp_top_properties
	import ftp_pkg::*;
(
	input wire logic I_SYS_CLK,
	input wire logic I_SRST,
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic [DATA_W-1:0] O_RDATA,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic O_IRQ
);
default clocking @(posedge I_SYS_CLK); endclocking
default disable iff (I_SRST);
//****
// properties
//****
rd_answer_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
	else $error("read not answered");
wr_answer_a: assert property
	(I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID)
	else $error("write not answered");
rsvd_zero_a: assert property
	(O_RVALID |-> (O_RDATA & ~SOURCE_BITS) == '0)
	else $error("reserved bit set");
rd_hold_a: assert property
	(O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
	else $error("read data dropped");
rd_done_a: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
	else $error("read not retired");
wr_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
	else $error("write response dropped");
wr_block_a: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
	else $error("write taken while busy");
rd_block_a: assert property (O_RVALID |-> !O_ARREADY)
	else $error("read taken while busy");
rst_clear_a: assert property
	($fell(I_SRST) |-> !O_RVALID && !O_BVALID && !O_IRQ)
	else $error("outputs not cleared");
endmodule
bind ftp_top ftp_top_properties u_prop (.*);
`default_nettype wire

// >>> ftp_src_model.sv
// model of the interrupt sources behind the summary
// assumes the caller runs in the clock domain of i_clk
`timescale 1ns/100ps
`default_nettype none
module ftp_src_model
	import ftp_pkg::*;
(
	input wire logic i_clk,
	output var ftp_source_t o_src [DATA_W]
);
initial
	foreach (o_src[k]) o_src[k] = '0;
// only source i live, all others idle
task automatic set(input int i, input logic [6:0] v);
	@(posedge i_clk);
	foreach (o_src[k]) o_src[k] <= (k == i) ? v : 7'h00;
endtask
task automatic add(input int i, input logic [6:0] v);
	@(posedge i_clk);
	o_src[i] <= v;
endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for ftp_top over axi4-lite
// assumes ftp_src_model drives the sources
`timescale 1ns/100ps
`default_nettype none
module tb_top;
import ftp_pkg::*;
logic sys_clk = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0;
logic arvalid = 0, rready = 0, awready, wready, bvalid, arready;
logic rvalid, irq;
logic [3:0] wstrb = 4'hF;
logic [15:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0, rdata, d, e;
logic [1:0] bresp, rresp, r;
ftp_source_t src [DATA_W];
int fails = 0, samples_checked = 0;
always #20 sys_clk = ~sys_clk;
ftp_src_model sm (.i_clk(sys_clk), .o_src(src));
ftp_top dut (.I_SYS_CLK(sys_clk), .I_SRST(srst), .I_SRC(src),
	.I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
	.I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
	.O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
	.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
	.O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
	.O_RVALID(rvalid), .I_RREADY(rready), .O_IRQ(irq));
//****
// tasks
//****
task automatic chk(input logic [31:0] s, input logic [31:0] x);
	samples_checked++;
	if (s !== x)
	begin
		fails++;
		$display("[ERR] %0t got %h exp %h", $time, s, x);
	end
endtask
task automatic close_out();
	$display("fails=%0d checks=%0d", fails, samples_checked);
	if (fails == 0 && samples_checked > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
// each request held until its ready is seen high at a rising edge
task automatic wr(input logic [15:0] a, input logic [31:0] v);
	@(posedge sys_clk);
	awaddr <= a;
	wdata <= v;
	awvalid <= 1'b1;
	wvalid <= 1'b1;
	bready <= 1'b1;
	do
	begin
		@(posedge sys_clk);
		if (awvalid && awready) awvalid <= 1'b0;
		if (wvalid && wready) wvalid <= 1'b0;
	end
	while (!(bvalid && bready));
	r = bresp;
	bready <= 1'b0;
endtask
task automatic rd(input logic [15:0] a);
	@(posedge sys_clk);
	araddr <= a;
	arvalid <= 1'b1;
	rready <= 1'b1;
	do
	begin
		@(posedge sys_clk);
		if (arvalid && arready) arvalid <= 1'b0;
	end
	while (!(rvalid && rready));
	d = rdata;
	r = rresp;
	rready <= 1'b0;
endtask
//****
// tests
//****
initial
begin
	#200000;
	$display("[ERR] %0t timeout", $time);
	fails++;
	close_out();
end
initial
begin
	repeat (20) @(posedge sys_clk);
	srst <= 1'b0;
	rd(TOP_PENDING_OFFSET);
	chk(d, TOP_PENDING_RESET);
	chk({30'h0, r}, {30'h0, RESP_OKAY});
	rd(IRQ_MASK_OFFSET);
	chk(d, IRQ_MASK_RESET);
	rd(16'h0100);
	chk({d[31:2], r}, {30'h0, RESP_SLVERR});
	for (int i = 0; i < DATA_W; i++)
	begin
		sm.set(i, 7'h75);
		repeat (3) @(posedge sys_clk);
		rd(TOP_PENDING_OFFSET);
		e = SOURCE_BITS & (32'h1 << i);
		chk(d, e);
	end
	sm.set(WAN_TX_FIQ_TOP, 7'h72);
	sm.add(DRAM_CTRL_FIQ_TOP, 7'h79);
	sm.add(LAN_TX_FIQ_TOP, 7'h79);
	sm.add(CRYPTO_ENGINE_FIQ_TOP, 7'h5F);
	repeat (3) @(posedge sys_clk);
	rd(TOP_PENDING_OFFSET);
	chk(d, 32'h00020010);
	sm.add(LAN_TX_FIQ_TOP, 7'h69);
	wr(TOP_PENDING_OFFSET, 32'hFFFFFFFF);
	chk({30'h0, r}, {30'h0, RESP_OKAY});
	rd(TOP_PENDING_OFFSET);
	chk(d, 32'h00000010);
	rd(IRQ_STATUS_OFFSET);
	chk(d, SOURCE_BITS);
	chk({31'h0, irq}, 32'h0);
	wr(IRQ_MASK_OFFSET, 32'h00000010);
	repeat (2) @(posedge sys_clk);
	chk({31'h0, irq}, 32'h1);
	wr(IRQ_STATUS_OFFSET, 32'hFFFFFFFF);
	repeat (2) @(posedge sys_clk);
	chk({31'h0, irq}, 32'h0);
	rd(IRQ_STATUS_OFFSET);
	chk(d, 32'h0);
	wstrb <= 4'h1;
	wr(IRQ_MASK_OFFSET, 32'hFFFFFFFF);
	rd(IRQ_MASK_OFFSET);
	chk(d, SOURCE_BITS & 32'h000000FF);
	wstrb <= 4'hF;
	wr(16'h0100, 32'h00000000);
	chk({30'h0, r}, {30'h0, RESP_SLVERR});
	close_out();
end
endmodule
`default_nettype wire
